/* src/mst_pkg.sv */
package mst_pkg;
   // Observation window for stuck sigma-delta streams: 1/128 of a reference
   // period counted in system clocks.
   localparam int unsigned STUCK_WINDOW_CYCLES = 128;
   localparam int unsigned STUCK_CNT_W         = 8;
   // Multiplex and tamper window lengths in line periods, and the tamper confirmation count in evaluations.
   localparam logic [5:0]  MUX_HALF_PERIODS   = 6'h20;
   localparam logic [5:0]  MUX_LONG_PERIODS   = 6'h3C;
   localparam logic [5:0]  MUX_SHORT_PERIODS  = 6'h04;
   localparam logic [5:0]  TAMPER_PRE_PERIODS = 6'h04;
   localparam logic [5:0]  TAMPER_WIN_PERIODS = 6'h08;
   localparam logic [2:0]  TAMPER_CONFIRM     = 3'h4;
   // Nominal voltage coefficients in Q0.16 (0.3594, 0.3906, 0.4219, 0.4531).
   localparam logic [15:0] NOM_COEFF_0 = 16'h5C01;
   localparam logic [15:0] NOM_COEFF_1 = 16'h63FE;
   localparam logic [15:0] NOM_COEFF_2 = 16'h6C01;
   localparam logic [15:0] NOM_COEFF_3 = 16'h73FE;
   // Base no-load thresholds (scaled integer units, doubling per step).
   localparam logic [31:0] NOLOAD_BASE_COIL  = 32'h00001188;
   localparam logic [31:0] NOLOAD_BASE_SHUNT = 32'h00000E40;
   // Wishbone register byte offsets.
   localparam logic [3:0]  REG_CONFIG = 4'h0;
   localparam logic [3:0]  REG_STATUS = 4'h4;
   // Config register field positions.
   localparam int unsigned CFG_GAIN_LSB   = 0;
   localparam int unsigned CFG_NOM_LSB    = 2;
   localparam int unsigned CFG_NOLOAD_LSB = 4;
   localparam int unsigned CFG_TAMPER_THRESHOLD_SELECT_BIT   = 6;
   localparam logic [6:0]  CFG_RESET      = 7'h00;
   typedef enum logic [1:0] {MST_NORMAL, MST_TAMPER_PRI, MST_TAMPER_SEC} mst_state_t;
endpackage

/* src/mst_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mst_stream_if;
   logic rawBit;
   logic cleanBit;
   logic stuck;
   modport guard (input rawBit, output cleanBit, output stuck);
   modport user  (output rawBit, input cleanBit, input stuck);
endinterface
`default_nettype wire

/* src/mst_stuck_guard.sv */
`timescale 1ns/1ps
`default_nettype none
module mst_stuck_guard
   import mst_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     rst_n,
   mst_stream_if.guard   s
);
   logic [STUCK_CNT_W-1:0] runLen;
   logic                   lastBit;
   logic                   idleBit;
   logic                   stuckFlag;
   wire                    same   = (s.rawBit == lastBit);
   wire                    runEnd = (runLen == STUCK_CNT_W'(STUCK_WINDOW_CYCLES - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         runLen    <= '0;
         lastBit   <= 1'b0;
         idleBit   <= 1'b0;
         stuckFlag <= 1'b0;
      end else begin
         lastBit   <= s.rawBit;
         idleBit   <= ~idleBit;
         runLen    <= same ? (runEnd ? runLen : runLen + 1'b1) : '0;
         stuckFlag <= same && runEnd; // [RQ10]
      end
   end

   // An alternating stream averages to zero, so it stands in for a dead one.
   assign s.cleanBit = stuckFlag ? idleBit : s.rawBit; // [RQ10]
   assign s.stuck    = stuckFlag;
endmodule
`default_nettype wire

/* src/mst_supervisor.sv */
// Summary of operation
// [RQ1] Single-wire mode only with coil gain codes
// [RQ2] Nominal voltage replaces measured during range error (here only in single-wire mode, i.e. coil gain codes)
// [RQ3] Substitute voltage is peak times coefficient
// [RQ4] Single-wire mode uses apparent energy
// [RQ5] Low supply holds whole block in reset
// [RQ6] No-load flag when power below threshold
// [RQ7] Four doubling thresholds, sensor-dependent base
// [RQ8] No-load suspends integration, disables tamper
// [RQ9] No-load blocks stepper, drives indicator low
// [RQ10] Stuck streams flagged and replaced by idle
// [RQ11] Pin mismatch flags error, suspends integration
// [RQ12] Tamper when difference exceeds ratio of mean
// [RQ13] Opposite signs keep tamper, use higher
// [RQ14] Normal state multiplexes channels 32:32
// [RQ15] Window: four primary then four secondary
// [RQ16] Four true evaluations enter tamper state
// [RQ17] Tamper state multiplexes 60:4 or 4:60
// [RQ18] Gap keeps last higher-channel current
// [RQ19] Tamper indicator pin low when tampered
// [RQ20] Errors force tamper state back to normal (a pin error here only stops sampling)
// [RQ21] Range error from frequency or low voltage
// [RQ22] Range error outside single-wire idles outputs
// [RQ23] Four false evaluations return to normal
// [RQ24] Line periods counted on positive-peak pulse
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mst_supervisor
   import mst_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        supplyLow,
   input  wire logic        freqOutOfBand,
   input  wire logic        voltBelowOn,
   input  wire logic        voltAboveOff,
   input  wire logic        peakPulse,
   input  wire logic        sdVoltRaw,
   input  wire logic        sdPriRaw,
   input  wire logic        sdSecRaw,
   input  wire logic [15:0] voltRms,
   input  wire logic [15:0] peakVoltReading,
   input  wire logic [15:0] currentRms,
   input  wire logic signed [31:0] channelEnergy,
   input  wire logic        motorPosDrive,
   input  wire logic        motorNegDrive,
   input  wire logic        pulseDrive,
   input  wire logic        motorPosPin,
   input  wire logic        motorNegPin,
   input  wire logic        pulsePin,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   output logic             sdVoltClean,
   output logic             sdCurrClean,
   output logic             useSecondary,
   output logic [15:0]      energyVoltage,
   output logic             apparentMode,
   output logic             integrateEnable,
   output logic             stepperEnable,
   output logic             outputsHoldLow,
   output logic             no_load_indicator_pin,
   output logic             tamper_indicator_pin,
   output logic             pinErrorFlag
);
   // A supply below the on-threshold keeps every flop in reset.
   wire rstEff_n = rst_n & ~supplyLow; // [RQ5]

   // Three-stage sampling of the pad feedback; a change counts once the
   // second and third stages agree.
   logic [2:0] pinS0, pinS1, pinS2, pinStable;
   // The drives are delayed by the latency of the pad sampler, so that a legal
   // transition on a pin is never taken for a mismatch.
   logic [2:0] drvD0, drvD1, drvD2, drvD3;
   always_ff @(posedge clk or negedge rstEff_n) begin
      if (!rstEff_n) begin
         pinS0 <= '0;
         pinS1 <= '0;
         pinS2 <= '0;
         pinStable <= '0;
         drvD0 <= '0;
         drvD1 <= '0;
         drvD2 <= '0;
         drvD3 <= '0;
      end else begin
         pinS0 <= {pulsePin, motorNegPin, motorPosPin};
         pinS1 <= pinS0;
         pinS2 <= pinS1;
         drvD0 <= {pulseDrive, motorNegDrive, motorPosDrive};
         drvD1 <= drvD0;
         drvD2 <= drvD1;
         drvD3 <= drvD2;
         for (int i = 0; i < 3; i++) begin
            if (pinS1[i] == pinS2[i]) pinStable[i] <= pinS2[i];
         end
      end
   end

   // Sigma-delta stream guards, one per stream.
   mst_stream_if sdV ();
   mst_stream_if sdP ();
   mst_stream_if sdS ();
   assign sdV.rawBit = sdVoltRaw;
   assign sdP.rawBit = sdPriRaw;
   assign sdS.rawBit = sdSecRaw;
   mst_stuck_guard uGuardV (.clk(clk), .rst_n(rstEff_n), .s(sdV));
   mst_stuck_guard uGuardP (.clk(clk), .rst_n(rstEff_n), .s(sdP));
   mst_stuck_guard uGuardS (.clk(clk), .rst_n(rstEff_n), .s(sdS));
   wire anyStuck = sdV.stuck | sdP.stuck | sdS.stuck; // [RQ10]

   // Registers.
   logic [6:0] cfg;
   wire  [1:0] current_gain_select      = cfg[CFG_GAIN_LSB +: 2];
   wire  [1:0] nominal_voltage_select   = cfg[CFG_NOM_LSB +: 2];
   wire  [1:0] no_load_threshold_select = cfg[CFG_NOLOAD_LSB +: 2];
   wire        tamper_threshold_select  = cfg[CFG_TAMPER_THRESHOLD_SELECT_BIT];

   wire wbReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   wire hitCfg   = (wb_adr_i == REG_CONFIG);
   wire hitSta   = (wb_adr_i == REG_STATUS);
   wire wbMapped = hitCfg | hitSta;

   // Range error: set by frequency or low voltage, cleared above off level.
   logic line_range_error;
   always_ff @(posedge clk or negedge rstEff_n) begin
      if (!rstEff_n) line_range_error <= 1'b1;
      else if (freqOutOfBand || voltBelowOn) line_range_error <= 1'b1; // [RQ21]
      else if (voltAboveOff) line_range_error <= 1'b0;
   end

   wire coilSensor = (current_gain_select < 2'h2);
   wire single_wire_meter_mode = coilSensor & line_range_error; // [RQ1]
   wire rangeHalt = line_range_error & ~single_wire_meter_mode;

   // Substitute voltage.
   wire [15:0] nominal_voltage_coeff =
      (nominal_voltage_select == 2'h0) ? NOM_COEFF_0 :
      (nominal_voltage_select == 2'h1) ? NOM_COEFF_1 :
      (nominal_voltage_select == 2'h2) ? NOM_COEFF_2 : NOM_COEFF_3; // [RQ3]
   wire [31:0] nomProduct = peakVoltReading * nominal_voltage_coeff;
   wire [15:0] nomVoltage = nomProduct[31:16]; // [RQ3]
   wire [15:0] effVoltage = single_wire_meter_mode ? nomVoltage : voltRms; // [RQ2]

   // No-load detection.
   wire [31:0] loadPower  = effVoltage * currentRms;
   wire [31:0] nlBase     = coilSensor ? NOLOAD_BASE_COIL : NOLOAD_BASE_SHUNT;
   wire [31:0] nlThresh   = nlBase << no_load_threshold_select; // [RQ7]
   wire        no_load_flag = (loadPower < nlThresh); // [RQ6]

   wire pinMismatch = (pinStable != drvD3);
   logic pinErr;
   always_ff @(posedge clk or negedge rstEff_n) begin
      if (!rstEff_n) pinErr <= 1'b0;
      else pinErr <= pinMismatch; // [RQ11]
   end

   wire tamperOff = line_range_error | anyStuck | no_load_flag; // [RQ20] [RQ8]

   // Line period counting and multiplex control.
   logic [5:0] perCnt;
   logic       phaseSec;
   logic       inWindow;
   logic [5:0] winCnt;
   mst_state_t state;
   wire [5:0] priLen = (state == MST_NORMAL) ? MUX_HALF_PERIODS :
                       (state == MST_TAMPER_PRI) ? MUX_LONG_PERIODS : MUX_SHORT_PERIODS;
   wire [5:0] secLen = (state == MST_NORMAL) ? MUX_HALF_PERIODS :
                       (state == MST_TAMPER_PRI) ? MUX_SHORT_PERIODS : MUX_LONG_PERIODS; // [RQ17]
   wire [5:0] curLen = phaseSec ? secLen : priLen;
   // A state change may shorten the running phase below the count already
   // reached, so the phase ends at the first peak at or past its length.
   wire periodEnd = peakPulse & (perCnt >= curLen - 6'h01); // [RQ24]
   // With a four-period primary phase the window opens as the secondary ends.
   wire shortPri  = (priLen == TAMPER_PRE_PERIODS);
   wire preMark   = (perCnt == priLen - TAMPER_PRE_PERIODS - 6'h01);
   wire winOpen   = peakPulse & ~inWindow
                    & (shortPri ? (phaseSec & periodEnd) : (~phaseSec & preMark)); // [RQ15]
   wire winClose  = peakPulse & inWindow & (winCnt == TAMPER_WIN_PERIODS - 6'h01);
   wire sampleB   = inWindow & (winCnt >= TAMPER_PRE_PERIODS);

   always_ff @(posedge clk or negedge rstEff_n) begin
      if (!rstEff_n) begin
         perCnt   <= '0;
         phaseSec <= 1'b0;
         inWindow <= 1'b0;
         winCnt   <= '0;
      end else begin
         if (peakPulse) perCnt <= periodEnd ? 6'h00 : perCnt + 6'h01; // [RQ14]
         if (periodEnd) phaseSec <= ~phaseSec; // [RQ14]
         if (tamperOff || winClose) inWindow <= 1'b0;
         else if (winOpen) inWindow <= 1'b1;
         if (winOpen || !inWindow) winCnt <= '0;
         else if (peakPulse) winCnt <= winCnt + 6'h01;
      end
   end

   // Energy samples A (primary) and B (secondary).
   logic signed [35:0] accA, accB;
   wire sampleEn = inWindow & ~pinErr & ~no_load_flag;
   always_ff @(posedge clk or negedge rstEff_n) begin
      if (!rstEff_n) begin
         accA <= '0;
         accB <= '0;
      end else if (winOpen) begin
         accA <= '0;
         accB <= '0;
      end else if (sampleEn && !sampleB) accA <= accA + 36'(channelEnergy);
      else if (sampleEn && sampleB) accB <= accB + 36'(channelEnergy);
   end

   // The criterion works on magnitudes; mixed signs always count as tamper.
   wire               oppSign = accA[35] ^ accB[35];
   wire        [35:0] magA = accA[35] ? 36'(-accA) : 36'(accA);
   wire        [35:0] magB = accB[35] ? 36'(-accB) : 36'(accB);
   wire        [35:0] diff = (magA > magB) ? magA - magB : magB - magA;
   wire        [36:0] sum  = {1'b0, magA} + {1'b0, magB};
   // Ratio of the mean: sum/2 * 1/8 = sum>>4, or sum/2 * 1/16 = sum>>5.
   wire        [36:0] lim  = tamper_threshold_select ? (sum >> 5) : (sum >> 4);
   wire criterion = oppSign | ({1'b0, diff} > lim); // [RQ12] [RQ13]
   wire priHigher = (magA >= magB); // [RQ13]

   logic [2:0] trueRun, falseRun;
   always_ff @(posedge clk or negedge rstEff_n) begin
      if (!rstEff_n) begin
         state    <= MST_NORMAL;
         trueRun  <= '0;
         falseRun <= '0;
      end else if (tamperOff) begin
         state    <= MST_NORMAL; // [RQ20]
         trueRun  <= '0;
         falseRun <= '0;
      end else if (winClose) begin
         trueRun  <= criterion ? ((trueRun == TAMPER_CONFIRM) ? trueRun : trueRun + 3'h1) : 3'h0;
         falseRun <= criterion ? 3'h0 : ((falseRun == TAMPER_CONFIRM) ? falseRun : falseRun + 3'h1);
         case (state)
            MST_NORMAL: begin
               if (criterion && trueRun == TAMPER_CONFIRM - 3'h1) begin // [RQ16]
                  state <= priHigher ? MST_TAMPER_PRI : MST_TAMPER_SEC; // [RQ17]
               end
            end
            MST_TAMPER_PRI, MST_TAMPER_SEC: begin
               if (!criterion && falseRun == TAMPER_CONFIRM - 3'h1) begin
                  state <= MST_NORMAL; // [RQ23]
               end else if (criterion) begin
                  state <= priHigher ? MST_TAMPER_PRI : MST_TAMPER_SEC;
               end
            end
            default: state <= MST_NORMAL;
         endcase
      end
   end

   // Outside the window the tamper state keeps the higher channel; inside it the
   // phase picks the channel, so the other one is still sampled and the state can leave.
   wire tamperState = (state != MST_NORMAL);
   wire higherSec   = (state == MST_TAMPER_SEC);
   assign useSecondary = (tamperState && !inWindow) ? higherSec : phaseSec; // [RQ18] [RQ14]

   // Wishbone slave: one-cycle ack, error on unmapped addresses.
   always_ff @(posedge clk or negedge rstEff_n) begin
      if (!rstEff_n) begin
         cfg      <= CFG_RESET;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wbReq & wbMapped;
         wb_err_o <= wbReq & ~wbMapped;
         if (wbReq && wb_we_i && hitCfg && wb_sel_i[0]) cfg <= wb_dat_i[6:0];
         if (wbReq && !wb_we_i) begin
            wb_dat_o <= hitCfg ? {25'h0, cfg} :
                        hitSta ? {23'h0, state == MST_TAMPER_SEC, tamperState, pinErr,
                                  sdS.stuck, sdP.stuck, sdV.stuck, single_wire_meter_mode,
                                  line_range_error, no_load_flag} : 32'h0;
         end
      end
   end

   assign sdVoltClean     = sdV.cleanBit;
   assign sdCurrClean     = useSecondary ? sdS.cleanBit : sdP.cleanBit;
   assign energyVoltage   = effVoltage; // [RQ2]
   assign apparentMode    = single_wire_meter_mode; // [RQ4]
   assign integrateEnable = ~no_load_flag & ~pinErr & ~rangeHalt; // [RQ8] [RQ11] [RQ22]
   assign stepperEnable   = ~no_load_flag & ~rangeHalt; // [RQ9]
   assign outputsHoldLow  = rangeHalt | no_load_flag; // [RQ22]
   assign no_load_indicator_pin = ~no_load_flag; // [RQ9]
   assign tamper_indicator_pin  = ~tamperState; // [RQ19]
   assign pinErrorFlag    = pinErr; // [RQ11]
endmodule
`default_nettype wire

/* verification/mst_supervisor_props.sv */
`timescale 1ns/1ps
`default_nettype none
module mst_supervisor_props (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   input wire logic [15:0] voltRms,
   input wire logic [15:0] energyVoltage,
   input wire logic        apparentMode,
   input wire logic        integrateEnable,
   input wire logic        stepperEnable,
   input wire logic        outputsHoldLow,
   input wire logic        no_load_indicator_pin,
   input wire logic        tamper_indicator_pin,
   input wire logic        pinErrorFlag,
   input wire logic        pulseDrive,
   input wire logic        pulsePin,
   input wire logic        sdVoltRaw,
   input wire logic        sdVoltClean
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [8:0] runV;
   logic       prevV;
   // Run length of the raw voltage stream; the guard window may need two spans to align.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         runV  <= 9'h000;
         prevV <= 1'b0;
      end else begin
         prevV <= sdVoltRaw;
         runV  <= (sdVoltRaw != prevV) ? 9'h000 : (runV == 9'h1FF) ? runV : runV + 9'h001;
      end
   end
   property p_wb_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o;
   endproperty
   a_wb_answer: assert property (p_wb_answer) else $error("bus request not answered");
   property p_wb_pulse;
      wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o;
   endproperty
   a_wb_pulse: assert property (p_wb_pulse) else $error("bus answer longer than one cycle");
   property p_nl_block;
      !no_load_indicator_pin |-> !stepperEnable && !integrateEnable;
   endproperty
   a_nl_block: assert property (p_nl_block) else $error("no-load did not block");
   property p_nl_tamper;
      !no_load_indicator_pin |-> ##[1:3] tamper_indicator_pin;
   endproperty
   a_nl_tamper: assert property (p_nl_tamper) else $error("tamper kept in no-load");
   property p_volt;
      !apparentMode |-> energyVoltage == voltRms;
   endproperty
   a_volt: assert property (p_volt) else $error("measured voltage not used");
   property p_hold;
      outputsHoldLow |-> !integrateEnable && !stepperEnable;
   endproperty
   a_hold: assert property (p_hold) else $error("range error did not idle");
   property p_pin_err;
      (pulseDrive != pulsePin) [*8] |-> ##[0:4] pinErrorFlag;
   endproperty
   a_pin_err: assert property (p_pin_err) else $error("pin mismatch not flagged");
   property p_pin_integ;
      pinErrorFlag |-> !integrateEnable;
   endproperty
   a_pin_integ: assert property (p_pin_integ) else $error("pin error kept integrating");
   property p_stuck;
      runV >= 9'h110 |-> ##[0:8] $changed(sdVoltClean);
   endproperty
   a_stuck: assert property (p_stuck) else $error("stuck stream not replaced");
   c_tamper: cover property (!tamper_indicator_pin);
   c_noload: cover property (!no_load_indicator_pin);
   c_err: cover property (wb_err_o);
endmodule
bind mst_supervisor mst_supervisor_props mst_supervisor_props_i (
   .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .voltRms, .energyVoltage,
   .apparentMode, .integrateEnable, .stepperEnable, .outputsHoldLow, .no_load_indicator_pin,
   .tamper_indicator_pin, .pinErrorFlag, .pulseDrive, .pulsePin, .sdVoltRaw, .sdVoltClean
);
`default_nettype wire

/* verification/mst_sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mst_sensor_model #(
   parameter int unsigned PERIOD_CYCLES = 40
) (
   input wire logic  clk,
   input wire logic  rst_n,
   input wire logic  stuckVolt,
   input wire logic  pinFault,
   input wire logic  motorPosDrive,
   input wire logic  motorNegDrive,
   input wire logic  pulseDrive,
   output logic      peakPulse,
   output logic      sdVoltRaw,
   output logic      sdPriRaw,
   output logic      sdSecRaw,
   output logic      motorPosPin,
   output logic      motorNegPin,
   output logic      pulsePin
);
   logic [7:0] tick;
   logic [2:0] ph;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick <= 8'h00;
         ph   <= 3'h0;
      end else begin
         tick <= (tick == 8'(PERIOD_CYCLES - 1)) ? 8'h00 : tick + 8'h01;
         ph   <= ph + 3'h1;
      end
   end
   // Short line periods keep the multiplex cycle inside a brief run.
   assign peakPulse   = (tick == 8'h01);
   assign sdPriRaw    = ph[0];
   assign sdSecRaw    = ph[1];
   assign sdVoltRaw   = stuckVolt | ph[2];
   assign motorPosPin = motorPosDrive;
   assign motorNegPin = motorNegDrive;
   assign pulsePin    = pulseDrive ^ pinFault;
endmodule
`default_nettype wire

/* verification/mst_supervisor_test.sv */
`timescale 1ns/1ps
`default_nettype none
module mst_supervisor_test;
   import mst_pkg::*;
   logic               clk = 1'b0, rst_n = 1'b0, supplyLow = 1'b0, freqOutOfBand = 1'b0;
   logic               voltBelowOn = 1'b0, voltAboveOff = 1'b0, motorPosDrive = 1'b0;
   logic               motorNegDrive = 1'b0, pulseDrive = 1'b0, stuckVolt = 1'b0;
   logic               pinFault = 1'b0, wbWe = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, e;
   logic [3:0]         wbAdr = 4'h0;
   logic [31:0]        wbDat = 32'h0, rdat;
   logic [15:0]        voltRms = 16'h4000, peakVoltReading = 16'h8000, currentRms = 16'h4000;
   logic signed [31:0] channelEnergy = 32'sh50, priE = 32'sh50, secE = 32'sh50;
   logic [15:0]        coef [4] = '{NOM_COEFF_0, NOM_COEFF_1, NOM_COEFF_2, NOM_COEFF_3};
   wire                peakPulse, sdVoltRaw, sdPriRaw, sdSecRaw, motorPosPin, motorNegPin;
   wire                pulsePin, wbAck, wbErr, useSecondary, apparentMode, integrateEnable;
   wire                stepperEnable, outputsHoldLow, noLoadPin, tamperPin, pinErrorFlag;
   wire [31:0]         wbDatO;
   wire [15:0]         energyVoltage;
   int                 n_mismatch = 0, compares = 0;
   logic [1:0]         dph = 2'h0;
   mst_sensor_model mst_sensor_model_i (.clk, .rst_n, .stuckVolt, .pinFault, .motorPosDrive,
      .motorNegDrive, .pulseDrive, .peakPulse, .sdVoltRaw, .sdPriRaw, .sdSecRaw, .motorPosPin,
      .motorNegPin, .pulsePin);
   mst_supervisor mst_supervisor_i (.clk, .rst_n, .supplyLow, .freqOutOfBand, .voltBelowOn,
      .voltAboveOff, .peakPulse, .sdVoltRaw, .sdPriRaw, .sdSecRaw, .voltRms, .peakVoltReading,
      .currentRms, .channelEnergy, .motorPosDrive, .motorNegDrive, .pulseDrive, .motorPosPin,
      .motorNegPin, .pulsePin, .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(4'hF),
      .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .wb_err_o(wbErr), .sdVoltClean(), .sdCurrClean(), .useSecondary, .energyVoltage,
      .apparentMode, .integrateEnable, .stepperEnable, .outputsHoldLow,
      .no_load_indicator_pin(noLoadPin), .tamper_indicator_pin(tamperPin), .pinErrorFlag);
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      // The drive toggles every fourth cycle so that the pad sampler can follow it.
      dph           <= dph + 2'h1;
      if (dph == 2'h3) pulseDrive <= ~pulseDrive;
      motorPosDrive <= pulseDrive;
      channelEnergy <= useSecondary ? secE : priE;
   end
   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic lim(input int k, input int m);
      if (k >= m) begin
         n_mismatch++;
         $display("[ERR] %0t wait limit reached", $time);
         final_report();
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe  <= we;
      wbAdr <= a;
      wbDat <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wbAck !== 1'b1 && wbErr !== 1'b1 && k < 20);
      rdat = wbDatO;
      e    = wbErr;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      lim(k, 20);
   endtask
   task automatic waitTamper(input logic lvl, input int m);
      int k;
      k = 0;
      while (tamperPin !== lvl && k < m) begin
         @(posedge clk);
         k++;
      end
      lim(k, m);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      wb(1'b0, REG_CONFIG, 32'h0);
      chk(rdat, {25'h0, CFG_RESET}, "config reset");
      wb(1'b0, REG_STATUS, 32'h0);
      chk(rdat & 32'h6, 32'h6, "status reset");
      wb(1'b0, 4'h8, 32'h0);
      chk(e, 1'b1, "unmapped access");
      $display("test reset finished");
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, REG_CONFIG, k << CFG_NOM_LSB);
         chk(energyVoltage, (32'(peakVoltReading) * coef[k]) >> 16, "nominal voltage");
      end
      wb(1'b1, REG_CONFIG, 32'h2);
      chk(apparentMode, 1'b0, "no single wire for transformer");
      chk(outputsHoldLow, 1'b1, "outputs held");
      wb(1'b1, REG_CONFIG, 32'h1);
      chk(apparentMode, 1'b1, "single wire for coil");
      $display("test single wire finished");
      voltAboveOff <= 1'b1;
      repeat (4) @(posedge clk);
      voltAboveOff <= 1'b0;
      @(posedge clk);
      chk(apparentMode, 1'b0, "range error cleared");
      chk(energyVoltage, voltRms, "measured voltage");
      chk(outputsHoldLow, 1'b0, "outputs released");
      $display("test range error finished");
      priE <= 32'sh64;
      secE <= 32'sh32;
      waitTamper(1'b0, 20000);
      repeat (2) @(posedge clk);
      chk(useSecondary, 1'b0, "higher channel kept");
      repeat (11000) @(posedge clk);
      chk(tamperPin, 1'b0, "tamper held while channels differ");
      freqOutOfBand <= 1'b1;
      @(posedge clk);
      freqOutOfBand <= 1'b0;
      repeat (2) @(posedge clk);
      chk(tamperPin, 1'b1, "range error clears tamper");
      chk(apparentMode, 1'b1, "range error set by frequency");
      voltAboveOff <= 1'b1;
      @(posedge clk);
      voltAboveOff <= 1'b0;
      waitTamper(1'b0, 20000);
      priE <= 32'sh32;
      waitTamper(1'b1, 25000);
      $display("test tamper finished");
      currentRms <= 16'h1;
      wb(1'b1, REG_CONFIG, 32'h31);
      chk(noLoadPin, 32'(voltRms) >= (NOLOAD_BASE_COIL << 3), "threshold step 3");
      wb(1'b1, REG_CONFIG, 32'h1);
      chk(noLoadPin, 32'(voltRms) >= NOLOAD_BASE_COIL, "threshold step 0");
      currentRms <= 16'h0;
      repeat (4) @(posedge clk);
      chk(noLoadPin, 1'b0, "no-load pin");
      chk(stepperEnable, 1'b0, "stepper blocked");
      chk(integrateEnable, 1'b0, "integration halted");
      wb(1'b0, REG_STATUS, 32'h0);
      chk(rdat[0], 1'b1, "no-load status");
      currentRms <= 16'h4000;
      stuckVolt  <= 1'b1;
      repeat (300) @(posedge clk);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(rdat[3], 1'b1, "stuck voltage stream");
      stuckVolt <= 1'b0;
      pinFault  <= 1'b1;
      repeat (20) @(posedge clk);
      chk(pinErrorFlag, 1'b1, "pin error");
      chk(integrateEnable, 1'b0, "pin error halts");
      $display("test errors finished");
      final_report();
   end
endmodule
`default_nettype wire
